//--- pkg/bxv_defines.svh
// constants for the 18-bit two-way bus transceiver block
// assumes inclusion by bare name from the package and the design file
`ifndef BXV_DEFINES_SVH
`define BXV_DEFINES_SVH

`define BXV_DATA_W 18
`define BXV_FIFO_DEPTH 8
`define BXV_DIR_FWD 0
`define BXV_DIR_REV 1
`define BXV_CTL_OE_N 0
`define BXV_CTL_LE 1
`define BXV_CTL_CLK 2
`define BXV_CTL_GATE_N 3
`define BXV_CTL_W 4
`define BXV_CTL_RESET 4'h1
`define BXV_ADDR_W 8
`define BXV_REG_CTRL 8'h00
`define BXV_REG_STATUS 8'h04
`define BXV_REG_LOG 8'h08
`define BXV_REG_FWD_STORE 8'h0C
`define BXV_REG_REV_STORE 8'h10
`define BXV_CTRL_LOG_EN 0
`define BXV_STATUS_OVF 0
`define BXV_STATUS_COUNT_LSB 8
`define BXV_STATUS_FWD_MODE_LSB 16
`define BXV_STATUS_REV_MODE_LSB 20
`define BXV_RESET_WORD 32'h0000_0000

`endif

//--- pkg/bxv_pkg.sv
// types for the 18-bit two-way bus transceiver block
// assumes the constants header sits beside it on the include path
`include "bxv_defines.svh"

package bxv_pkg;
	typedef logic [`BXV_DATA_W-1:0] bxv_word_t;
	typedef logic [`BXV_ADDR_W-1:0] bxv_addr_t;
	typedef enum logic [1:0] {BXV_PASS, BXV_HOLD, BXV_CLOCKED, BXV_GATED} bxv_mode_t;
endpackage

//--- logic/bxv_transceiver.sv
// 18-bit two-way bus transceiver with per-direction latch/flip-flop storage,
// a capture log fifo and a small register port.
// assumes: pins and control inputs are asynchronous to REF_CLK; the pads
// resolve each bus from *_OUT and *_OE; register master obeys the plain port.
// Behaviour
// RULE_01: eighteen bits carried each way, separate controls per direction
// RULE_02: each direction uses only its own controls
// RULE_03: forward latch enable high passes data through
// RULE_04: latch low, steady clock holds stored data
// RULE_05: falling clock edge with gate low captures
// RULE_06: gate high blocks clock edges, output holds
// RULE_07: output enable low drives, high releases bus
// RULE_08: driver keeps clock high when latch falls
// RULE_09: reverse direction mirrors forward with own controls
// RULE_10: storage keeps working while outputs released
`include "bxv_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module bxv_fifo #(
	parameter int W = `BXV_DATA_W,
	parameter int DEPTH = `BXV_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [W-1:0] mem_reg [DEPTH];
	logic [W-1:0] mem_next [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic push, pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign in_ready = (cnt_reg != CW'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem_reg[rd_reg];
	assign count = cnt_reg;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		mem_next = mem_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		if (push) begin
			mem_next[wr_reg] = in_data;
			wr_next = bump(wr_reg);
		end
		if (pop) begin
			rd_next = bump(rd_reg);
		end
		if (push && !pop) begin
			cnt_next = CW'(cnt_reg + 1'b1);
		end else if (pop && !push) begin
			cnt_next = CW'(cnt_reg - 1'b1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
			mem_reg <= mem_next;
		end
	end
endmodule

module bxv_transceiver #(
	parameter int DATA_W = `BXV_DATA_W,
	parameter int LOG_DEPTH = `BXV_FIFO_DEPTH
) (
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic [DATA_W-1:0] A_IN,
	output logic [DATA_W-1:0] A_OUT,
	output logic A_OE,
	input wire logic [DATA_W-1:0] B_IN,
	output logic [DATA_W-1:0] B_OUT,
	output logic B_OE,
	input wire logic FWD_OUTPUT_ENABLE_N,
	input wire logic FWD_TRANSPARENT_ENABLE,
	input wire logic FWD_CAPTURE_CLOCK,
	input wire logic FWD_CAPTURE_GATE_N,
	input wire logic REV_OUTPUT_ENABLE_N,
	input wire logic REV_TRANSPARENT_ENABLE,
	input wire logic REV_CAPTURE_CLOCK,
	input wire logic REV_CAPTURE_GATE_N,
	input wire bxv_pkg::bxv_addr_t REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA
);
	import bxv_pkg::*;

	logic [DATA_W-1:0] din_pin [2];
	logic [`BXV_CTL_W-1:0] ctl_pin [2];
	logic [DATA_W-1:0] store_w [2];
	logic [DATA_W-1:0] dout_w [2];
	logic [DATA_W-1:0] din_w [2];
	logic oe_w [2];
	logic cap_w [2];
	bxv_mode_t mode_w [2];

	assign din_pin[`BXV_DIR_FWD] = A_IN;
	assign din_pin[`BXV_DIR_REV] = B_IN;
	assign ctl_pin[`BXV_DIR_FWD] = {FWD_CAPTURE_GATE_N, FWD_CAPTURE_CLOCK,
		FWD_TRANSPARENT_ENABLE, FWD_OUTPUT_ENABLE_N};
	assign ctl_pin[`BXV_DIR_REV] = {REV_CAPTURE_GATE_N, REV_CAPTURE_CLOCK,
		REV_TRANSPARENT_ENABLE, REV_OUTPUT_ENABLE_N};

	// both directions are the same hardware; each sees only its own pins
	for (genvar d = 0; d < 2; d++) begin : g_dir
		logic [`BXV_CTL_W-1:0] ctl_s1_reg, ctl_s2_reg;
		logic [DATA_W-1:0] din_s1_reg, din_s2_reg;
		logic clk_prev_reg, clk_prev_next;
		logic [DATA_W-1:0] store_reg, store_next, dout_reg, dout_next;
		logic oe_reg, oe_next, le, gate_n, fall, cap;

		always_comb begin
			le = ctl_s2_reg[`BXV_CTL_LE];
			gate_n = ctl_s2_reg[`BXV_CTL_GATE_N];
			// edge seen on synchronised clock, so the capture clock must be
			// slower than a few REF_CLK periods per phase
			fall = clk_prev_reg && !ctl_s2_reg[`BXV_CTL_CLK];
			cap = !le && !gate_n && fall; // [RULE_05] [RULE_06]
			clk_prev_next = ctl_s2_reg[`BXV_CTL_CLK];
			store_next = store_reg; // [RULE_04]
			if (le || cap) begin
				store_next = din_s2_reg; // [RULE_03] [RULE_05] [RULE_10]
			end
			dout_next = store_next; // [RULE_01]
			oe_next = !ctl_s2_reg[`BXV_CTL_OE_N]; // [RULE_07]
		end

		always_ff @(posedge REF_CLK) begin
			if (!RST_B) begin
				// enable-low pin resets inactive so no bus is driven on release
				ctl_s1_reg <= `BXV_CTL_RESET;
				ctl_s2_reg <= `BXV_CTL_RESET;
				din_s1_reg <= '0;
				din_s2_reg <= '0;
				clk_prev_reg <= 1'b0;
				store_reg <= '0;
				dout_reg <= '0;
				oe_reg <= 1'b0;
			end else begin
				ctl_s1_reg <= ctl_pin[d]; // [RULE_02] [RULE_09]
				ctl_s2_reg <= ctl_s1_reg;
				din_s1_reg <= din_pin[d];
				din_s2_reg <= din_s1_reg;
				clk_prev_reg <= clk_prev_next;
				store_reg <= store_next;
				dout_reg <= dout_next;
				oe_reg <= oe_next;
			end
		end

		assign store_w[d] = store_reg;
		assign dout_w[d] = dout_reg;
		assign din_w[d] = din_s2_reg;
		assign oe_w[d] = oe_reg;
		assign cap_w[d] = cap;
		// clocked mode shows only in the cycle of the edge itself
		assign mode_w[d] = le ? BXV_PASS : (gate_n ? BXV_GATED :
			(fall ? BXV_CLOCKED : BXV_HOLD));
	end

	assign B_OUT = dout_w[`BXV_DIR_FWD];
	assign B_OE = oe_w[`BXV_DIR_FWD];
	assign A_OUT = dout_w[`BXV_DIR_REV];
	assign A_OE = oe_w[`BXV_DIR_REV];

	// capture log: forward clocked captures queued for software to read
	localparam int CW = $clog2(LOG_DEPTH + 1);
	logic log_en_reg, log_en_next, ovf_reg, ovf_next;
	logic [31:0] rdata_reg, rdata_next;
	logic log_push, log_ready, log_valid, log_pop;
	logic [DATA_W-1:0] log_data;
	logic [CW-1:0] log_count;

	bxv_fifo #(.W(DATA_W), .DEPTH(LOG_DEPTH)) u_log (
		.clk(REF_CLK),
		.rst_b(RST_B),
		.in_valid(log_push),
		.in_ready(log_ready),
		.in_data(din_w[`BXV_DIR_FWD]),
		.out_valid(log_valid),
		.out_ready(log_pop),
		.out_data(log_data),
		.count(log_count)
	);

	always_comb begin
		log_push = log_en_reg && cap_w[`BXV_DIR_FWD];
		log_pop = REG_RD && (REG_ADDR == `BXV_REG_LOG) && log_valid;
		log_en_next = log_en_reg;
		ovf_next = ovf_reg;
		rdata_next = `BXV_RESET_WORD;
		if (REG_WR && REG_ADDR == `BXV_REG_CTRL) begin
			log_en_next = REG_WDATA[`BXV_CTRL_LOG_EN];
		end
		if (REG_WR && REG_ADDR == `BXV_REG_STATUS && REG_WDATA[`BXV_STATUS_OVF]) begin
			ovf_next = 1'b0;
		end
		// a lost capture in the clearing cycle still sets the flag
		if (log_push && !log_ready) begin
			ovf_next = 1'b1;
		end
		if (REG_RD) begin
			case (REG_ADDR)
				`BXV_REG_CTRL: rdata_next[`BXV_CTRL_LOG_EN] = log_en_reg;
				`BXV_REG_STATUS: begin
					rdata_next[`BXV_STATUS_OVF] = ovf_reg;
					rdata_next[`BXV_STATUS_COUNT_LSB +: CW] = log_count;
					rdata_next[`BXV_STATUS_FWD_MODE_LSB +: 2] = mode_w[`BXV_DIR_FWD];
					rdata_next[`BXV_STATUS_REV_MODE_LSB +: 2] = mode_w[`BXV_DIR_REV];
				end
				`BXV_REG_LOG: begin
					if (log_valid) begin
						rdata_next[DATA_W-1:0] = log_data;
					end
				end
				`BXV_REG_FWD_STORE: rdata_next[DATA_W-1:0] = store_w[`BXV_DIR_FWD];
				`BXV_REG_REV_STORE: rdata_next[DATA_W-1:0] = store_w[`BXV_DIR_REV];
				default: rdata_next = `BXV_RESET_WORD;
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			log_en_reg <= 1'b0;
			ovf_reg <= 1'b0;
			rdata_reg <= `BXV_RESET_WORD;
		end else begin
			log_en_reg <= log_en_next;
			ovf_reg <= ovf_next;
			rdata_reg <= rdata_next;
		end
	end

	assign REG_RDATA = rdata_reg;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);

	a_pin_to_out: assert property (g_dir[0].le && $past(RST_B, 3) |=> // [RULE_01]
		B_OUT == $past(A_IN, 3)) else $error("forward pass-through value wrong");
	a_dir_independent: assert property (!g_dir[0].le && !g_dir[0].cap |=> // [RULE_02]
		$stable(B_OUT)) else $error("forward output moved without own control");
	a_transparent_pass: assert property (g_dir[0].le |=> // [RULE_03]
		B_OUT == $past(g_dir[0].din_s2_reg)) else $error("transparent mode not passing");
	a_hold_steady: assert property (!g_dir[0].le && !g_dir[0].fall |=> // [RULE_04]
		$stable(g_dir[0].store_reg)) else $error("stored value changed while holding");
	a_fall_capture: assert property (g_dir[0].cap |=> // [RULE_05]
		B_OUT == $past(g_dir[0].din_s2_reg)) else $error("falling edge did not capture");
	a_gate_blocks: assert property (!g_dir[0].le && g_dir[0].gate_n && g_dir[0].fall |=> // [RULE_06]
		$stable(B_OUT)) else $error("gated edge changed output");
	a_oe_follows: assert property ($rose(g_dir[0].ctl_s2_reg[`BXV_CTL_OE_N]) |=> // [RULE_07]
		!B_OE ##1 !B_OE || !$past(g_dir[0].ctl_s2_reg[`BXV_CTL_OE_N]))
		else $error("output enable did not release");
	a_rev_capture: assert property (g_dir[1].cap || g_dir[1].le |=> // [RULE_09]
		A_OUT == $past(g_dir[1].din_s2_reg)) else $error("reverse direction wrong");
	a_store_in_hiz: assert property (!B_OE && g_dir[0].cap |=> // [RULE_10]
		g_dir[0].store_reg == $past(g_dir[0].din_s2_reg)) else $error("no capture while released");
	a_oe_drive: assert property ($fell(g_dir[0].ctl_s2_reg[`BXV_CTL_OE_N]) |=> // [RULE_07]
		B_OE) else $error("output enable did not drive");
	a_rev_release: assert property ($rose(g_dir[1].ctl_s2_reg[`BXV_CTL_OE_N]) |=> // [RULE_09]
		!A_OE) else $error("reverse output enable did not release");
	a_rev_hold: assert property (!g_dir[1].le && !g_dir[1].cap |=> // [RULE_09]
		$stable(A_OUT)) else $error("reverse output moved while holding");

	c_fwd_pass: cover property (g_dir[0].le ##1 B_OE);
	c_fwd_capture: cover property (g_dir[0].cap ##1 B_OE);
	c_rev_capture: cover property (g_dir[1].cap);
	c_log_overflow: cover property (log_push && !log_ready);
	c_store_in_hiz: cover property (!B_OE && g_dir[0].cap);
endmodule

`default_nettype wire

//--- testbench/bxv_bus_partner.sv
// far-side bus logic for the transceiver: drives the A and B pins
// assumes the bench supplies the values; device enables decide who owns each bus
`timescale 1ns/1ps
`default_nettype none
module bxv_bus_partner (
	input wire bxv_pkg::bxv_word_t a_out,
	input wire logic a_oe,
	input wire bxv_pkg::bxv_word_t b_out,
	input wire logic b_oe,
	input wire bxv_pkg::bxv_word_t a_val,
	input wire bxv_pkg::bxv_word_t b_val,
	output var bxv_pkg::bxv_word_t a_pin,
	output var bxv_pkg::bxv_word_t b_pin
);
	import bxv_pkg::*;
	// one owner per bus: the device wins while enabled, so no contention to model
	always_comb begin
		a_pin = a_oe ? a_out : a_val;
		b_pin = b_oe ? b_out : b_val;
	end
endmodule
`default_nettype wire

//--- testbench/bxv_transceiver_test.sv
// bench for the two-way transceiver: both directions, register port, capture log
// assumes the design files and the bus partner model are compiled first
`timescale 1ns/1ps
`include "bxv_defines.svh"
`default_nettype none
module bxv_transceiver_test;
	import bxv_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] c [2] = '{4'h5, 4'h5};
	bxv_word_t a_in, b_in, a_out, b_out;
	bxv_word_t a_val = '0;
	bxv_word_t b_val = '0;
	logic a_oe, b_oe;
	logic wr = 1'b0;
	logic rd = 1'b0;
	bxv_addr_t addr = '0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata, v;
	int miscompares = 0;
	int tests_run = 0;
	bxv_word_t q[$];
	bxv_word_t r[3];
	initial begin
		forever #4 clk = ~clk;
	end
	bxv_transceiver u_dut (.REF_CLK(clk), .RST_B(rst_b), .A_IN(a_in), .A_OUT(a_out),
		.A_OE(a_oe), .B_IN(b_in), .B_OUT(b_out), .B_OE(b_oe),
		.FWD_OUTPUT_ENABLE_N(c[0][`BXV_CTL_OE_N]), .FWD_TRANSPARENT_ENABLE(c[0][`BXV_CTL_LE]),
		.FWD_CAPTURE_CLOCK(c[0][`BXV_CTL_CLK]), .FWD_CAPTURE_GATE_N(c[0][`BXV_CTL_GATE_N]),
		.REV_OUTPUT_ENABLE_N(c[1][`BXV_CTL_OE_N]), .REV_TRANSPARENT_ENABLE(c[1][`BXV_CTL_LE]),
		.REV_CAPTURE_CLOCK(c[1][`BXV_CTL_CLK]), .REV_CAPTURE_GATE_N(c[1][`BXV_CTL_GATE_N]),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
	bxv_bus_partner u_bus (.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
		.a_val(a_val), .b_val(b_val), .a_pin(a_in), .b_pin(b_in));
	function automatic logic [31:0] outv(input int d);
		return (d == 0) ? {14'h0, b_out} : {14'h0, a_out};
	endfunction
	function automatic logic [31:0] oe(input int d);
		return {31'h0, (d == 0) ? b_oe : a_oe};
	endfunction
	function automatic bxv_addr_t store_addr(input int d);
		return (d == 0) ? `BXV_REG_FWD_STORE : `BXV_REG_REV_STORE;
	endfunction
	function automatic logic [31:0] status_exp(input logic [3:0] n, input logic ovf);
		return {20'h0, n, 7'h0, ovf};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_mode(input int d, input bxv_mode_t m);
		logic [31:0] s;
		rd32(`BXV_REG_STATUS, s);
		s = s >> ((d == 0) ? `BXV_STATUS_FWD_MODE_LSB : `BXV_STATUS_REV_MODE_LSB);
		chk(s & 32'h3, 32'(m));
	endtask
	// x is {gate_n, clock, transparent, oe_n}; each phase held well past the sync delay
	task automatic ctl(input int d, input logic [3:0] x);
		@(posedge clk);
		c[d] <= x;
		repeat (5) @(posedge clk);
		#1;
	endtask
	task automatic src(input int d, input bxv_word_t x);
		@(posedge clk);
		if (d == 0) begin
			a_val <= x;
		end else begin
			b_val <= x;
		end
		repeat (4) @(posedge clk);
	endtask
	task automatic wr32(input bxv_addr_t a, input logic [31:0] x);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= x;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd32(input bxv_addr_t a, output logic [31:0] x);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		x = rdata;
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#50000;
		miscompares++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h090D0144));
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		for (int d = 0; d < 2; d++) begin
			foreach (r[i]) r[i] = bxv_word_t'($urandom);
			src(d, r[0]);
			ctl(d, 4'h6);
			chk(outv(d), {14'h0, r[0]});
			chk(oe(d), 32'h1);
			chk_mode(d, BXV_PASS);
			ctl(d, 4'h4); // transparent drops while the clock is high
			src(d, r[1]);
			chk(outv(d), {14'h0, r[0]});
			chk_mode(d, BXV_HOLD);
			ctl(d, 4'h0);
			chk(outv(d), {14'h0, r[1]});
			ctl(d, 4'h8);
			src(d, r[2]);
			ctl(d, 4'hC);
			ctl(d, 4'h8);
			chk(outv(d), {14'h0, r[1]});
			chk_mode(d, BXV_GATED);
			ctl(d, 4'h5);
			chk(oe(d), 32'h0);
			chk(oe(1 - d), 32'h0);
			ctl(d, 4'h1);
			rd32(store_addr(d), v);
			chk(v, {14'h0, r[2]});
			ctl(d, 4'h0);
			chk(outv(d), {14'h0, r[2]});
			ctl(d, 4'h5);
			$display("direction %0d test done", d);
		end
		rd32(8'h40, v);
		chk(v, 32'h0);
		wr32(`BXV_REG_CTRL, 32'h1);
		rd32(`BXV_REG_CTRL, v);
		chk(v, 32'h1);
		// one capture more than the log holds, so the last one is refused
		for (int i = 0; i < `BXV_FIFO_DEPTH + 1; i++) begin
			r[0] = bxv_word_t'($urandom);
			src(0, r[0]);
			ctl(0, 4'h5);
			ctl(0, 4'h1);
			if (i < `BXV_FIFO_DEPTH) begin
				q.push_back(r[0]);
			end
		end
		rd32(`BXV_REG_STATUS, v);
		chk(v & 32'hFFF, status_exp(4'h8, 1'b1));
		wr32(`BXV_REG_STATUS, 32'h1);
		rd32(`BXV_REG_STATUS, v);
		chk(v & 32'hFFF, status_exp(4'h8, 1'b0));
		while (q.size() > 0) begin
			rd32(`BXV_REG_LOG, v);
			chk(v, {14'h0, q.pop_front()});
		end
		rd32(`BXV_REG_LOG, v);
		chk(v, 32'h0);
		$display("capture log test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
